// >>> dv/pbws_far_end.sv
// Model of switch, wake sources and operating system.
// Assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/1ns
module pbws_far_end (
    input  wire logic            i_sys_clk,     // Standby clock
    output logic                 o_pwr_sw,      // Power switch, high while pressed
    output logic                 o_chassis_sw,  // Cover switch
    output logic                 o_sleep_en,    // Short press maps to standby
    output logic                 o_cmd_valid,   // Command strobe
    output logic                 o_intr_clr,    // Intrusion clear
    output pbws_pkg::pbws_wake_s o_wake,        // Wake lines
    output pbws_pkg::pbws_cmd_e  o_os_cmd       // Command code
);
    import pbws_pkg::*;
    // Quiet lines at time zero
    initial begin
        {o_pwr_sw, o_chassis_sw, o_sleep_en, o_cmd_valid, o_intr_clr} = 5'h00;
        o_wake   = '0;
        o_os_cmd = PBWS_CMD_NONE;
    end
    // One-cycle command strobe from the OS
    task automatic os_request(input pbws_cmd_e cmd);
        @(negedge i_sys_clk);
        o_os_cmd    = cmd;
        o_cmd_valid = 1'b1;
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b0;
        o_os_cmd    = PBWS_CMD_NONE;
    endtask : os_request
    // Wake line high four cycles; bit 6 stands for a received wake frame
    task automatic wake_pulse(input int idx);
        @(negedge i_sys_clk);
        o_wake[idx] = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        o_wake = '0;
    endtask : wake_pulse
    // Cover switch and clear levels
    task automatic set_misc(input logic closed, input logic clr);
        @(negedge i_sys_clk);
        o_chassis_sw = closed;
        o_intr_clr   = clr;
    endtask : set_misc
    // Hold the switch for a number of cycles, then let the debounce drain
    task automatic press(input int cycles);
        @(negedge i_sys_clk);
        o_pwr_sw = 1'b1;
        repeat (cycles) @(negedge i_sys_clk);
        o_pwr_sw = 1'b0;
        repeat (12) @(negedge i_sys_clk);
    endtask : press
    // OS choice for a short press while working
    task automatic set_sleep(input logic en);
        @(negedge i_sys_clk);
        o_sleep_en = en;
    endtask : set_sleep
endmodule : pbws_far_end

// >>> dv/pbws_seq_props.sv
// Port checker for the power-button sequencer.
// Assumes a bind onto pbws_sequencer and one standby clock.
`timescale 1ns/1ns
module pbws_seq_props #(
    parameter int unsigned SHORT_CYC = 40,  // Short-press limit
    parameter int unsigned LONG_CYC  = 80,  // Override threshold
    parameter int unsigned DB_CYC    = 4    // Switch settle time
) (
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst_b,
    input wire logic                  i_pwr_sw,
    input wire logic                  i_chassis_sw,
    input wire pbws_pkg::pbws_wake_s  i_wake,
    input wire logic                  i_os_sleep_en,
    input wire pbws_pkg::pbws_cmd_e   i_os_cmd,
    input wire logic                  i_os_cmd_valid,
    input wire logic                  i_intr_clr,
    input wire pbws_pkg::pbws_state_e o_state,
    input wire pbws_pkg::pbws_pwr_s   o_pwr,
    input wire logic                  o_intrusion,
    input wire logic                  o_wake_evt
);
    import pbws_pkg::*;
    // Quiet long enough that the synchronisers and the switch debounce have drained
    localparam logic [31:0] QUIET_MAX = 32'(DB_CYC) + 32'h0000_0008;
    logic [31:0] quiet_reg;                                  // Cycles with no deep wake source
    wire         deep_quiet = ~|(i_wake & 8'hC7) && !i_pwr_sw; // Only S3-only lines may be high
    wire  [31:0] quiet_next = !deep_quiet ? 32'h0000_0000 :
                              (quiet_reg == QUIET_MAX) ? QUIET_MAX : quiet_reg + 32'h0000_0001;
    wire        cmd_s0     = i_os_cmd_valid && (o_state == PBWS_S0); // Command that is honoured
    // Saturating quiet-time counter
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) quiet_reg <= 32'h0000_0000;
        else quiet_reg <= quiet_next;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_soft_off_cmd: assert property (cmd_s0 && i_os_cmd == PBWS_CMD_SOFT_OFF |=>
        o_state == PBWS_S5 && o_pwr == 3'h0) else $error("Soft-off command not carried out");
    a_sleep_cmd: assert property (cmd_s0 && i_os_cmd == PBWS_CMD_SLEEP_S3 |=>
        o_state == PBWS_S3) else $error("Sleep command not carried out");
    a_fan_main_follow: assert property (o_pwr.fan_en == (o_state == PBWS_S0) &&
        o_pwr.main_pwr == o_pwr.fan_en) else $error("Fan or main enable wrong for state");
    a_usb_deep_off: assert property (o_state inside {PBWS_S4, PBWS_S5} |->
        !o_pwr.usb_pwr) else $error("USB power on in deep state");
    a_deep_wake_gate: assert property (quiet_reg == QUIET_MAX &&
        o_state inside {PBWS_S4, PBWS_S5} |=> $stable(o_state)) else $error("Deep state left");
    a_rtc_wakes: assert property ((o_state != PBWS_S0 && i_wake.rtc)[*3] |->
        ##[0:2] o_state == PBWS_S0) else $error("Alarm wake not taken");
    a_intr_set: assert property (i_chassis_sw[*3] |-> ##[0:2] o_intrusion)
        else $error("Intrusion not raised");
    a_wake_pulse: assert property (o_state == PBWS_S0 && $past(o_state) != PBWS_S0 |->
        o_wake_evt) else $error("Wake event missing");
    a_evt_single: assert property (o_wake_evt |=> !o_wake_evt)
        else $error("Wake event longer than one cycle");
    c_deep_sleep: cover property (cmd_s0 && i_os_cmd == PBWS_CMD_SLEEP_S4);
    c_wake: cover property (o_wake_evt);
    c_clear_held: cover property (o_intrusion && i_intr_clr);
endmodule : pbws_seq_props

bind pbws_sequencer pbws_seq_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
    .DB_CYC(DB_CYC)) i_props (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_pwr_sw(i_pwr_sw),
    .i_chassis_sw(i_chassis_sw), .i_wake(i_wake), .i_os_sleep_en(i_os_sleep_en),
    .i_os_cmd(i_os_cmd), .i_os_cmd_valid(i_os_cmd_valid), .i_intr_clr(i_intr_clr),
    .o_state(o_state), .o_pwr(o_pwr), .o_intrusion(o_intrusion), .o_wake_evt(o_wake_evt));

// >>> dv/power_button_wake_sequencer_bench.sv
// Self-checking bench for the power-button sequencer.
// Assumes pbws_pkg, the far-end model and the checker are compiled first.
`timescale 1ns/1ns
module power_button_wake_sequencer_bench;
    import pbws_pkg::*;
    logic        i_sys_clk = 1'b0;  // Standby clock
    logic        i_rst_b   = 1'b0;  // Reset, active low
    logic        pwr_sw, chassis_sw, sleep_en, cmd_valid, intr_clr, intrusion, wake_evt;
    pbws_wake_s  wake;              // Wake lines
    pbws_cmd_e   os_cmd;            // Command code
    pbws_state_e state;             // Observed state
    pbws_pwr_s   pwr;               // Observed enables
    int          bad_count = 0;     // Mismatches
    int          tests_run = 0;     // Comparisons
    int          deep[5] = '{7, 6, 2, 1, 0};  // Wake lines good in S3 to S5
    int          light[3] = '{5, 4, 3};       // Wake lines good in S3 only
    always #20 i_sys_clk = ~i_sys_clk;
    pbws_far_end i_far (.i_sys_clk(i_sys_clk), .o_pwr_sw(pwr_sw), .o_chassis_sw(chassis_sw),
        .o_sleep_en(sleep_en), .o_cmd_valid(cmd_valid), .o_intr_clr(intr_clr),
        .o_wake(wake), .o_os_cmd(os_cmd));
    pbws_sequencer #(.SHORT_CYC(40), .LONG_CYC(80), .DB_CYC(4)) i_dut (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_pwr_sw(pwr_sw), .i_chassis_sw(chassis_sw), .i_wake(wake),
        .i_os_sleep_en(sleep_en), .i_os_cmd(os_cmd), .i_os_cmd_valid(cmd_valid),
        .i_intr_clr(intr_clr), .o_state(state), .o_pwr(pwr), .o_intrusion(intrusion),
        .o_wake_evt(wake_evt));
    // Compare a state value
    task automatic chk_state(input pbws_state_e got, input pbws_state_e exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: state %h expected %h", $time, got, exp);
        end
    endtask : chk_state
    // Compare a flag or enable group
    task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: flags %h expected %h", $time, got, exp);
        end
    endtask : chk_flag
    // Pulse a wake line and count wake-event cycles while it is up and after
    task automatic wake_try(input int idx, input logic taken);
        int hits;
        hits = 0;
        fork
            i_far.wake_pulse(idx);
            repeat (8) begin
                @(negedge i_sys_clk);
                if (wake_evt === 1'b1) begin
                    hits++;
                end
            end
        join
        chk_flag(3'(hits), {2'h0, taken});
        chk_flag({2'h0, wake_evt}, 3'h0);
        if (taken) begin
            chk_state(state, PBWS_S0);
        end
    endtask : wake_try
    // Every deep source wakes from soft-off, then OS powers off
    task automatic t_deep_wakes;
        chk_flag(pwr, 3'h0);
        foreach (deep[i]) begin
            wake_try(deep[i], 1'b1);
            chk_flag(pwr, 3'h7);
            i_far.os_request(PBWS_CMD_SOFT_OFF);
            chk_state(state, PBWS_S5);
            chk_flag(pwr, 3'h0);
        end
        $display("Test deep_wakes done");
    endtask : t_deep_wakes
    // S3-only sources ignored in S4, commands refused there
    task automatic t_gated_s4;
        wake_try(7, 1'b1);
        i_far.os_request(PBWS_CMD_SLEEP_S4);
        chk_state(state, PBWS_S4);
        chk_flag(pwr, 3'h0);
        foreach (light[i]) begin
            wake_try(light[i], 1'b0);
        end
        i_far.os_request(PBWS_CMD_SOFT_OFF);
        chk_state(state, PBWS_S4);
        wake_try(1, 1'b1);
        $display("Test gated_s4 done");
    endtask : t_gated_s4
    // S3-only sources wake from S3
    task automatic t_s3_wakes;
        foreach (light[i]) begin
            i_far.os_request(PBWS_CMD_SLEEP_S3);
            chk_state(state, PBWS_S3);
            chk_flag(pwr, 3'h2);
            wake_try(light[i], 1'b1);
        end
        $display("Test s3_wakes done");
    endtask : t_s3_wakes
    // Switch presses: gated sleep, short wake, long override
    task automatic t_switch;
        i_far.press(10);
        chk_state(state, PBWS_S0);
        i_far.set_sleep(1'b1);
        i_far.press(10);
        chk_state(state, PBWS_S3);
        i_far.press(10);
        chk_state(state, PBWS_S0);
        i_far.press(100);
        chk_state(state, PBWS_S5);
        chk_flag(pwr, 3'h0);
        i_far.press(10);
        chk_state(state, PBWS_S0);
        i_far.os_request(PBWS_CMD_SLEEP_S4);
        i_far.press(100);
        chk_state(state, PBWS_S5);
        $display("Test switch done");
    endtask : t_switch
    // Closed cover switch raises a flag that holds until opened and cleared
    task automatic t_intrusion;
        chk_flag({2'h0, intrusion}, 3'h0);
        i_far.set_misc(1'b1, 1'b0);
        repeat (5) @(negedge i_sys_clk);
        chk_flag({2'h0, intrusion}, 3'h1);
        i_far.set_misc(1'b1, 1'b1);
        repeat (4) @(negedge i_sys_clk);
        chk_flag({2'h0, intrusion}, 3'h1);
        i_far.set_misc(1'b0, 1'b1);
        repeat (5) @(negedge i_sys_clk);
        chk_flag({2'h0, intrusion}, 3'h0);
        i_far.set_misc(1'b0, 1'b0);
        $display("Test intrusion done");
    endtask : t_intrusion
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (4) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        @(negedge i_sys_clk);
        t_deep_wakes();
        t_gated_s4();
        t_s3_wakes();
        t_switch();
        t_intrusion();
        tally_and_finish();
    end
    // Watchdog well past the expected few hundred cycles
    initial begin
        #(40 * 3000);
        bad_count++;
        tally_and_finish();
    end
endmodule : power_button_wake_sequencer_bench

// >>> pkg/pbws_defs.svh
// Timing counts, debounce figures and counter width for the power-button sequencer.
// Assumes a 25 MHz standby clock; included by the package and the design files.
`ifndef PBWS_DEFS_SVH
`define PBWS_DEFS_SVH

// Standby clock rate in Hz
`define PBWS_CLK_HZ            25000000
// Short-press limit in seconds
`define PBWS_SHORT_S           4
// Long-press override threshold in seconds
`define PBWS_LONG_S            6
// Debounce settle time in milliseconds
`define PBWS_DEBOUNCE_MS       20
// Cycles below which a press is short (longest time, rounds down)
`define PBWS_SHORT_CYC         (`PBWS_SHORT_S * `PBWS_CLK_HZ)
// Cycles above which a press forces soft-off (least time)
`define PBWS_LONG_CYC          (`PBWS_LONG_S * `PBWS_CLK_HZ)
// Debounce cycles
`define PBWS_DEBOUNCE_CYC      ((`PBWS_DEBOUNCE_MS * `PBWS_CLK_HZ) / 1000)
// Press counter width, enough for six seconds plus margin
`define PBWS_CNT_W             28

`endif

// >>> pkg/pbws_pkg.sv
// Types shared by the power-button sequencer and its debouncer.
// Assumes pbws_defs.svh is on the include path.
`include "pbws_defs.svh"

package pbws_pkg;

    // System sleeping states tracked by the sequencer
    typedef enum logic [1:0] {
        PBWS_S0,
        PBWS_S3,
        PBWS_S4,
        PBWS_S5
    } pbws_state_e;

    // Operating system command codes
    typedef enum logic [1:0] {
        PBWS_CMD_NONE,
        PBWS_CMD_SLEEP_S3,
        PBWS_CMD_SLEEP_S4,
        PBWS_CMD_SOFT_OFF
    } pbws_cmd_e;

    // Raw wake request lines, all active high after board inversion
    typedef struct packed {
        logic rtc;
        logic lan;
        logic usb;
        logic serial;
        logic ps2_any;
        logic ps2_alt_prt;
        logic pme;
        logic wake;
    } pbws_wake_s;

    // Supply and fan enables driven back to the board
    typedef struct packed {
        logic main_pwr;
        logic usb_pwr;
        logic fan_en;
    } pbws_pwr_s;

endpackage : pbws_pkg

// >>> verilog/pbws_debounce.sv
// Two-flop synchroniser and settle-timer debouncer for one switch input.
// Assumes an asynchronous level input and a free-running standby clock.
`timescale 1ns/1ns
`include "pbws_defs.svh"

module pbws_debounce #(
    parameter int unsigned DB_CYC = `PBWS_DEBOUNCE_CYC  // Settle time in cycles
) (
    input  wire logic i_sys_clk,  // Standby clock
    input  wire logic i_rst_b,    // Async reset, active low
    input  wire logic i_raw,      // Unsynchronised switch level
    output logic      o_level     // Debounced level
);
    import pbws_pkg::*;

    logic        meta_reg;   // First synchroniser stage, read only by sync_reg
    logic        sync_reg;   // Second synchroniser stage
    logic [19:0] cnt_reg;    // Settle counter
    logic        level_reg;  // Accepted level
    logic        differs;    // Synchronised input disagrees with accepted level
    logic        settled;    // Disagreement has held long enough

    assign differs = sync_reg != level_reg;
    assign settled = cnt_reg == 20'(DB_CYC - 1);
    assign o_level = level_reg;

    // Synchronise, then accept a new level after it holds steady
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg  <= 1'b0;
            sync_reg  <= 1'b0;
            cnt_reg   <= 20'h0_0000;
            level_reg <= 1'b0;
        end else begin
            meta_reg <= i_raw;
            sync_reg <= meta_reg;
            if (!differs) begin
                cnt_reg <= 20'h0_0000;        // Bounce restarts the wait
            end else if (settled) begin
                cnt_reg   <= 20'h0_0000;
                level_reg <= sync_reg;
            end else begin
                cnt_reg <= cnt_reg + 20'h0_0001;
            end
        end
    end

endmodule : pbws_debounce

// >>> verilog/pbws_sequencer.sv
// Power-state sequencer: switch timing, OS commands, wake gating, intrusion.
// Assumes all board inputs are asynchronous to the 25 MHz standby clock.
`timescale 1ns/1ns
`include "pbws_defs.svh"

// Functional notes
// - Short press wakes from off or sleep
// - Press over six seconds forces soft-off
// - Short press sleeps only when OS enabled
// - OS soft-off command removes main power
// - Switch, RTC, LAN, PME, WAKE, PS/2 wake S3-S5
// - USB and serial wake only from S3
// - USB power off in S4 and S5
// - Closed chassis switch raises intrusion event
// - Fans on in S0, off otherwise
// - S4/S5 PS/2 wake needs alt-PrintScreen only
module pbws_sequencer #(
    parameter int unsigned SHORT_CYC = `PBWS_SHORT_CYC,  // Short-press limit in cycles
    parameter int unsigned LONG_CYC  = `PBWS_LONG_CYC,   // Override threshold in cycles
    parameter int unsigned DB_CYC    = `PBWS_DEBOUNCE_CYC // Switch settle time in cycles
) (
    input  wire logic                 i_sys_clk,       // Standby clock
    input  wire logic                 i_rst_b,         // Standby reset, active low
    input  wire logic                 i_pwr_sw,        // Power switch, high while pressed
    input  wire logic                 i_chassis_sw,    // Cover switch, high when closed
    input  wire pbws_pkg::pbws_wake_s i_wake,          // Wake request lines
    input  wire logic                 i_os_sleep_en,   // OS maps short press to standby
    input  wire pbws_pkg::pbws_cmd_e  i_os_cmd,        // OS transition command
    input  wire logic                 i_os_cmd_valid,  // Command strobe, one cycle
    input  wire logic                 i_intr_clr,      // Clears intrusion flag
    output pbws_pkg::pbws_state_e     o_state,         // Current system state
    output pbws_pkg::pbws_pwr_s       o_pwr,           // Supply and fan enables
    output logic                      o_intrusion,     // Sticky intrusion flag
    output logic                      o_wake_evt       // Pulse when a wake is taken
);
    import pbws_pkg::*;

    // Counter wide enough for the override threshold at the standby rate
    localparam int CNT_W = `PBWS_CNT_W;

    // Press timing
    logic              sw_level;      // Debounced switch level
    logic              sw_prev_reg;   // Previous debounced level
    logic [CNT_W-1:0]  press_cnt_reg; // Cycles the switch has been held
    logic              long_done_reg; // Override already fired this press
    logic              sw_release;    // Release edge
    logic              short_press;   // Release of a press under four seconds
    logic              long_press;    // Hold reached the override threshold

    // Wake synchronisers, one per line
    logic [7:0]        wake_raw;      // Packed wake lines
    logic [7:0]        wake_meta_reg; // First stage
    logic [7:0]        wake_sync_reg; // Second stage
    pbws_wake_s        wk;            // Synchronised view
    logic              chas_meta_reg; // Chassis first stage
    logic              chas_sync_reg; // Chassis second stage

    // State
    pbws_state_e       state_reg;     // Present state
    pbws_state_e       state_next;    // Next state
    logic              intr_reg;      // Sticky intrusion flag
    logic              wake_evt_reg;  // Registered wake pulse
    pbws_pwr_s         pwr_reg;       // Registered enables
    pbws_pwr_s         pwr_next;      // Enables for next state

    // Wake qualification
    logic              in_s3;         // Suspended to RAM
    logic              in_deep;       // S4 or S5
    logic              wake_any_lvl;  // Sources valid from S3, S4 and S5
    logic              wake_s3_only;  // Sources valid from S3 only
    logic              wake_hit;      // A qualified wake this cycle
    logic              os_cmd_take;   // Valid OS command this cycle

    // Debounced power switch
    pbws_debounce #(.DB_CYC(DB_CYC)) u_sw_db (
        .i_sys_clk (i_sys_clk),
        .i_rst_b   (i_rst_b),
        .i_raw     (i_pwr_sw),
        .o_level   (sw_level)
    );

    assign wake_raw = i_wake;
    assign wk       = pbws_wake_s'(wake_sync_reg);

    // Two-flop synchronisers on every wake line
    // Each line has its own pair so a metastable first stage never reaches gating
    for (genvar g = 0; g < 8; g++) begin : g_wsync
        always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                wake_meta_reg[g] <= 1'b0;
                wake_sync_reg[g] <= 1'b0;
            end else begin
                wake_meta_reg[g] <= wake_raw[g];
                wake_sync_reg[g] <= wake_meta_reg[g];
            end
        end
    end

    // Press classification
    // A release between the short limit and the override does nothing
    assign sw_release  = sw_prev_reg && !sw_level;
    assign short_press = sw_release && (press_cnt_reg < CNT_W'(SHORT_CYC));
    assign long_press  = sw_level && !long_done_reg
                         && (press_cnt_reg >= CNT_W'(LONG_CYC));

    // Wake source gating by sleeping depth
    assign in_s3        = state_reg == PBWS_S3;
    assign in_deep      = (state_reg == PBWS_S4) || (state_reg == PBWS_S5);
    assign wake_any_lvl = wk.rtc || wk.lan || wk.pme || wk.wake;
    assign wake_s3_only = wk.usb || wk.serial || wk.ps2_any;
    // Alt-PrintScreen is ordinary keyboard activity while suspended to RAM
    assign wake_hit     = (in_s3 && (wake_any_lvl || wake_s3_only || wk.ps2_alt_prt
                          || short_press))
                          || (in_deep && (wake_any_lvl || wk.ps2_alt_prt
                          || short_press));
    assign os_cmd_take  = i_os_cmd_valid && (state_reg == PBWS_S0);

    // Next-state selection; override beats everything else in S0, S3 and S4
    // Commands are taken only while working; sleeping states ignore them
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PBWS_S0: begin
                if (long_press) begin
                    state_next = PBWS_S5;
                end else if (os_cmd_take && i_os_cmd == PBWS_CMD_SOFT_OFF) begin
                    state_next = PBWS_S5;
                end else if (os_cmd_take && i_os_cmd == PBWS_CMD_SLEEP_S3) begin
                    state_next = PBWS_S3;
                end else if (os_cmd_take && i_os_cmd == PBWS_CMD_SLEEP_S4) begin
                    state_next = PBWS_S4;
                end else if (short_press && i_os_sleep_en) begin
                    state_next = PBWS_S3;
                end
            end
            PBWS_S3, PBWS_S4: begin
                if (long_press) begin
                    state_next = PBWS_S5;
                end else if (wake_hit) begin
                    state_next = PBWS_S0;
                end
            end
            PBWS_S5: begin
                if (wake_hit) begin
                    state_next = PBWS_S0;
                end
            end
            default: begin
                state_next = PBWS_S5;
            end
        endcase
    end

    // Enables follow the next state
    // Taken from the next state so enables switch on the same edge as the state
    always_comb begin
        pwr_next.main_pwr = state_next == PBWS_S0;
        pwr_next.usb_pwr  = (state_next == PBWS_S0) || (state_next == PBWS_S3);
        pwr_next.fan_en   = state_next == PBWS_S0;
    end

    // Press counter, held at its ceiling
    // Saturating keeps a stuck switch from wrapping into a false short press
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sw_prev_reg   <= 1'b0;
            press_cnt_reg <= '0;
            long_done_reg <= 1'b0;
        end else begin
            sw_prev_reg <= sw_level;
            if (!sw_level) begin
                press_cnt_reg <= '0;
                long_done_reg <= 1'b0;
            end else begin
                if (press_cnt_reg != '1) begin
                    press_cnt_reg <= press_cnt_reg + CNT_W'(1);
                end
                if (long_press) begin
                    long_done_reg <= 1'b1;
                end
            end
        end
    end

    // State, enables and wake pulse
    // Reset lands in soft-off so the board powers up only on a wake
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg    <= PBWS_S5;
            pwr_reg      <= '0;
            wake_evt_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            pwr_reg      <= pwr_next;
            wake_evt_reg <= (state_reg != PBWS_S0) && (state_next == PBWS_S0);
        end
    end

    // Chassis switch sync and sticky intrusion flag, set wins over clear
    // A clear while the cover is still off is lost; the flag stays up
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chas_meta_reg <= 1'b0;
            chas_sync_reg <= 1'b0;
            intr_reg      <= 1'b0;
        end else begin
            chas_meta_reg <= i_chassis_sw;
            chas_sync_reg <= chas_meta_reg;
            if (chas_sync_reg) begin
                intr_reg <= 1'b1;
            end else if (i_intr_clr) begin
                intr_reg <= 1'b0;
            end
        end
    end

    // Outputs straight from registers
    assign o_state     = state_reg;
    assign o_pwr       = pwr_reg;
    assign o_intrusion = intr_reg;
    assign o_wake_evt  = wake_evt_reg;

endmodule : pbws_sequencer
